//--- design/pee_defs.svh
// Constants for the parallel EEPROM host controller
`ifndef PEE_DEFS_SVH
`define PEE_DEFS_SVH
`define PEE_CLK_HZ 20000000
`define PEE_ADDR_W 13
`define PEE_PAGE_LSB 6
`define PEE_POLL_BIT 7
`define PEE_TOGGLE_BIT 6
`define PEE_WP_NS 100
`define PEE_WP_CYC (((`PEE_WP_NS * 20) + 999) / 1000)
`define PEE_BLC_US 150
`define PEE_BLC_CYC ((`PEE_BLC_US * (`PEE_CLK_HZ / 1000000)) - 100)
`define PEE_TWC_MS 10
`define PEE_TWC_CYC (`PEE_TWC_MS * (`PEE_CLK_HZ / 1000))
`define PEE_PON_MS 5
`define PEE_PON_CYC (`PEE_PON_MS * (`PEE_CLK_HZ / 1000))
`define PEE_ID_BASE 13'h1fc0
`endif

//--- design/pee_pkg.sv
// Types shared by the parallel EEPROM host controller
package pee_pkg;
   typedef enum logic [6:0] {
      PEE_IDLE = 7'h01,
      PEE_RSET = 7'h02,
      PEE_RSMP = 7'h04,
      PEE_WLOW = 7'h08,
      PEE_WHI = 7'h10,
      PEE_POLL = 7'h20,
      PEE_PON = 7'h40
   } pee_state_e;
   typedef struct packed {
      logic write;
      logic [12:0] addr;
      logic [7:0] data;
      logic last;
      logic id_space;
   } pee_req_s;
   typedef struct packed {
      logic [12:0] address_bus;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic id_space_select_pin;
   } pee_pins_s;
endpackage : pee_pkg

//--- design/pee_host.sv
// Host controller driving a parallel page-write EEPROM over its pins
`timescale 1ns/1ps
`include "pee_defs.svh"

module pee_host #(
   parameter int unsigned TWC_CYC = `PEE_TWC_CYC,
   parameter int unsigned PON_CYC = `PEE_PON_CYC,
   parameter int unsigned BLC_CYC = `PEE_BLC_CYC
) (
   input wire logic mclk,
   input wire logic arst_n,
   // User request side
   input wire logic req_valid,
   output logic req_ready,
   input wire pee_pkg::pee_req_s req,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic busy,
   // Device pins
   output pee_pkg::pee_pins_s pins,
   input wire logic [7:0] data_pins_in,
   output logic [7:0] data_pins_out,
   output logic data_pins_oe_n
);
   import pee_pkg::*;

   // ************************************************************
   // State record
   // ************************************************************
   typedef struct packed {
      pee_state_e st;
      logic [31:0] cnt;
      logic [31:0] win;
      logic in_page;
      logic [6:0] page;
      logic prog_last;
      logic [7:0] prog_data;
      logic [7:0] last_rd;
      logic have_rd;
      pee_pins_s pins;
      logic [7:0] dout;
      logic drive;
      logic rsp_v;
      logic [7:0] rsp_d;
   } pee_st_s;

   pee_st_s s_r;
   pee_st_s s_nxt;

   // Polling is done when the poll bit matches and toggle bit holds still
   function automatic logic poll_done(input logic [7:0] rd, input logic [7:0] prev,
                                      input logic [7:0] exp, input logic have);
      poll_done = (rd[`PEE_POLL_BIT] == exp[`PEE_POLL_BIT])
                  && have && (rd[`PEE_TOGGLE_BIT] == prev[`PEE_TOGGLE_BIT]);
   endfunction : poll_done

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rsp_v = 1'b0;
      if (s_r.in_page && s_r.win != 32'h0)
         s_nxt.win = s_r.win - 32'h1;
      unique case (s_r.st)
         PEE_PON:
         begin
            // Power-on delay; the device ignores writes until it elapses
            if (s_r.cnt >= PON_CYC - 1)
            begin
               s_nxt.st = PEE_IDLE;
               s_nxt.cnt = 32'h0;
            end
            else
               s_nxt.cnt = s_r.cnt + 32'h1;
         end
         PEE_IDLE:
         begin
            // Window expired: device is now programming the page
            if (s_r.in_page && s_r.win == 32'h0)
            begin
               s_nxt.in_page = 1'b0;
               s_nxt.st = PEE_POLL;
               s_nxt.cnt = 32'h0;
               s_nxt.have_rd = 1'b0;
            end
            else if (req_valid && req.write && s_r.in_page && req.addr[12:6] != s_r.page)
            begin
               // Different page: wait for the open page to close first
               s_nxt.st = PEE_IDLE;
            end
            else if (req_valid)
            begin
               s_nxt.pins.address_bus = req.addr;
               s_nxt.pins.id_space_select_pin = req.id_space;
               s_nxt.pins.ce_n = 1'b0;
               s_nxt.cnt = 32'h0;
               if (req.write)
               begin
                  // Lock commands are plain user writes; low bits pick the byte
                  // OE high before WE falls so the write is not inhibited
                  s_nxt.pins.oe_n = 1'b1;
                  s_nxt.pins.we_n = 1'b0;
                  s_nxt.dout = req.data;
                  s_nxt.drive = 1'b1;
                  s_nxt.page = req.addr[12:6];
                  s_nxt.prog_last = req.last;
                  s_nxt.prog_data = req.data;
                  s_nxt.st = PEE_WLOW;
               end
               else
               begin
                  s_nxt.pins.we_n = 1'b1;
                  s_nxt.pins.oe_n = 1'b0;
                  s_nxt.drive = 1'b0;
                  s_nxt.st = PEE_RSET;
               end
            end
         end
         PEE_WLOW:
         begin
            // Address latched at WE fall, data at WE rise
            if (s_r.cnt >= `PEE_WP_CYC - 1)
            begin
               s_nxt.pins.we_n = 1'b1;
               s_nxt.st = PEE_WHI;
            end
            else
               s_nxt.cnt = s_r.cnt + 32'h1;
         end
         PEE_WHI:
         begin
            // Release CE and bus one cycle after the data edge for hold
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.drive = 1'b0;
            s_nxt.in_page = 1'b1;
            s_nxt.win = BLC_CYC;
            if (s_r.prog_last)
            begin
               // Last byte: let the window lapse so programming begins
               s_nxt.win = 32'h1;
            end
            s_nxt.st = PEE_IDLE;
         end
         PEE_RSET:
         begin
            // Access time is under two 50 ns cycles at the sample edge
            s_nxt.st = PEE_RSMP;
         end
         PEE_RSMP:
         begin
            s_nxt.rsp_v = 1'b1;
            s_nxt.rsp_d = data_pins_in;
            s_nxt.pins.oe_n = 1'b1;
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.st = PEE_IDLE;
         end
         PEE_POLL:
         begin
            // Each read ends with OE/CE high, which steps the toggle bit
            s_nxt.cnt = s_r.cnt + 32'h1;
            if (s_r.pins.oe_n)
            begin
               s_nxt.pins.address_bus = {s_r.page, s_r.pins.address_bus[5:0]};
               s_nxt.pins.oe_n = 1'b0;
               s_nxt.pins.ce_n = 1'b0;
            end
            else
            begin
               s_nxt.pins.oe_n = 1'b1;
               s_nxt.pins.ce_n = 1'b1;
               s_nxt.last_rd = data_pins_in;
               s_nxt.have_rd = 1'b1;
               // Timeout guards against a dead part; exceeds max cycle
               if (poll_done(data_pins_in, s_r.last_rd, s_r.prog_data, s_r.have_rd)
                   || s_r.cnt >= TWC_CYC)
               begin
                  s_nxt.st = PEE_IDLE;
               end
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_r <= '0;
         s_r.st <= PEE_PON;
         s_r.pins.ce_n <= 1'b1;
         s_r.pins.oe_n <= 1'b1;
         s_r.pins.we_n <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   // Ready only in idle with no page conflict or lapsed window
   assign req_ready = (s_r.st == PEE_IDLE) && !(s_r.in_page && s_r.win == 32'h0)
                      && !(req.write && s_r.in_page && req.addr[12:6] != s_r.page);
   assign busy = (s_r.st != PEE_IDLE) || s_r.in_page;
   assign rsp_valid = s_r.rsp_v;
   assign rsp_data = s_r.rsp_d;
   assign pins = s_r.pins;
   assign data_pins_out = s_r.dout;
   assign data_pins_oe_n = !s_r.drive;
endmodule : pee_host

//--- testbench/pee_host_checker.sv
// Pin and handshake assertions for the EEPROM host controller
`timescale 1ns/1ps
module pee_host_checker
   import pee_pkg::*;
#(
   parameter int unsigned PON_CYC = 20
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire pee_req_s req,
   input wire logic rsp_valid,
   input wire pee_pins_s pins,
   input wire logic [7:0] data_pins_out,
   input wire logic data_pins_oe_n
);
   // ****************
   // Properties
   // ****************
   int unsigned up_r;
   // Cycles since reset release, capped so it never wraps
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n) up_r <= 0;
      else if (up_r < PON_CYC) up_r <= up_r + 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_pon_no_ready: assert property (up_r < PON_CYC |-> !req_ready) else $error("ready in power-on delay");
   a_write_oe_high: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n && !data_pins_oe_n)
      else $error("bad write strobe mix");
   a_read_no_drive: assert property (!pins.oe_n |-> data_pins_oe_n && pins.we_n) else $error("bus clash");
   a_we_pulse_len: assert property ($fell(pins.we_n) |-> !pins.we_n ##1 !pins.we_n ##1 pins.we_n)
      else $error("write pulse length");
   a_addr_held: assert property (!pins.we_n |=> $stable(pins.address_bus)) else $error("address moved");
   a_data_held: assert property (!pins.we_n |=> $stable(data_pins_out) && !data_pins_oe_n)
      else $error("data moved");
   a_read_answer: assert property (req_valid && req_ready && !req.write |-> ##3 rsp_valid)
      else $error("read answer late");
   a_rsp_single: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
endmodule : pee_host_checker
bind pee_host pee_host_checker #(.PON_CYC(PON_CYC)) i_chk (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .pins(pins), .data_pins_out(data_pins_out),
   .data_pins_oe_n(data_pins_oe_n));

//--- testbench/pee_eeprom_model.sv
// Behavioural page-write EEPROM facing the host controller
`timescale 1ns/1ps
module pee_eeprom_model
   import pee_pkg::*;
#(
   parameter int PROG_CYC = 25
) (
   input wire logic mclk,
   input wire pee_pins_s pins,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out
);
   // ****************
   // Array and status
   // ****************
   logic [7:0] mem [16384];
   logic [13:0] wa = 14'h0000;
   logic [7:0] wd = 8'h00;
   logic [7:0] held = 8'h00;
   logic tog = 1'b0;
   logic act = 1'b0;
   int left = 0;
   wire rd = !pins.ce_n && !pins.oe_n && pins.we_n;
   wire [13:0] idx = {pins.id_space_select_pin && pins.address_bus >= 13'h1fc0, pins.address_bus};
   wire [7:0] val = (left > 0) ? {~wd[7], tog, 6'h00} : mem[idx];
   // Released bus shows inverted last value, never a stale copy
   assign dq_out = rd ? val : ~held;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // Address on the later falling strobe, only with output enable high
   always @(negedge pins.we_n or negedge pins.ce_n)
      if (!pins.we_n && !pins.ce_n && pins.oe_n) {act, wa} = {1'b1, idx};
   // Data on the first rising strobe; each load restarts the busy timer
   always @(posedge pins.we_n or posedge pins.ce_n)
      if (act) {act, mem[wa], wd, left} = {1'b0, dq_in, dq_in, PROG_CYC};
   always @(posedge pins.oe_n)
      if (left > 0) tog = ~tog;
   always @(posedge mclk)
   begin
      if (rd) held <= val;
      if (left > 0) left <= left - 1;
   end
endmodule : pee_eeprom_model

//--- testbench/testbench.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/1ps
module testbench;
   import pee_pkg::*;
   // ****************
   // Harness
   // ****************
   logic mclk = 0, arst_n = 0, req_valid = 0;
   pee_req_s req = '0;
   logic req_ready, rsp_valid, busy, data_pins_oe_n;
   logic [7:0] rsp_data, data_pins_out, dev_q, d;
   logic [12:0] a;
   logic [6:0] pg;
   pee_pins_s pins;
   int n_errors = 0, n_tests = 0, cyc = 0, seed = 32'he9fe;
   logic [7:0] exp_q[$];
   logic [7:0] shadow[int];
   wire [7:0] data_pins_in = data_pins_oe_n ? dev_q : data_pins_out;
   always #25 mclk = ~mclk;
   // Short counts keep the run small
   pee_host #(.TWC_CYC(50), .PON_CYC(20), .BLC_CYC(30)) i_dut (.mclk(mclk), .arst_n(arst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .busy(busy), .pins(pins), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
      .data_pins_oe_n(data_pins_oe_n));
   pee_eeprom_model i_dev (.mclk(mclk), .pins(pins), .dq_in(data_pins_out), .dq_out(dev_q));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // Hold the request until an edge takes it; reads note their expected byte
   task automatic issue(input logic w, input logic [12:0] ad, input logic [7:0] dt, input logic l, input logic id);
      req = '{w, ad, dt, l, id};
      req_valid = 1;
      while (req_ready !== 1'b1) begin @(posedge mclk); #1; end
      if (w) shadow[{id, ad}] = dt;
      else exp_q.push_back(shadow.exists({id, ad}) ? shadow[{id, ad}] : 8'hff);
      @(posedge mclk);
      #1 req_valid = 0;
      // Let one edge pass so a following call never re-raises valid in this step
      @(posedge mclk);
      #1;
   endtask : issue
   always @(posedge mclk)
      if (rsp_valid === 1'b1) check(rsp_data, exp_q.pop_front());
   // Hang guard
   always @(posedge mclk) if (++cyc == 20000) begin n_errors++; summarize(); end
   // ****************
   // Scenarios
   // ****************
   initial
   begin
      repeat (4) @(posedge mclk);
      #1 arst_n = 1;
      // Odd tests close the page, even ones let the window lapse; the last uses the id area
      for (int t = 0; t < 6; t++)
      begin
         pg = (t == 5) ? 7'h7f : 7'($random(seed));
         for (int k = 0; k < 3; k++)
         begin
            a = {pg, 6'($random(seed))};
            d = 8'($random(seed));
            issue(1, a, d, k == 2 && t[0], t == 5);
         end
         while (busy !== 1'b0) begin @(posedge mclk); #1; end
         issue(0, a, 0, 0, t == 5);
         for (int k = 0; k < 64; k += 9) issue(0, {pg, 6'(k)}, 0, 0, t == 5);
         $display("test %0d done", t);
      end
      repeat (20) @(posedge mclk);
      summarize();
   end
endmodule : testbench
